// [hdl/ptw_pkg.sv]
// Purpose: shared constants and types for the page table walker
// Assumes: 64-bit virtual addresses, 56-bit physical addresses, 8-byte entries
// Notes:   mode codes are the walker's own encoding of the translation mode field
package ptw_pkg;

   // ---------------------------------------------------------------
   // address geometry
   // ---------------------------------------------------------------
   localparam int unsigned VA_WIDTH       = 64;
   localparam int unsigned PA_WIDTH       = 56;
   localparam int unsigned PPN_WIDTH      = 44;
   localparam int unsigned OFFSET_WIDTH   = 12;  // untranslated page offset
   localparam int unsigned VPN_FIELD_BITS = 9;   // one table index
   localparam int unsigned PTE_BYTES      = 8;
   localparam int unsigned PTE_SHIFT      = 3;   // log2 of entry size

   // ---------------------------------------------------------------
   // translation modes: encoding and level counts
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_BARE  = 4'h0;
   localparam logic [3:0] MODE_VA39  = 4'h8;
   localparam logic [3:0] MODE_VA48  = 4'h9;
   localparam logic [3:0] MODE_VA57  = 4'ha;
   localparam logic [2:0] LEVELS_VA39 = 3'h3;
   localparam logic [2:0] LEVELS_VA48 = 3'h4;
   localparam logic [2:0] LEVELS_VA57 = 3'h5;
   localparam logic [2:0] LEVELS_NONE = 3'h0;   // bare, no walk
   localparam logic [2:0] LEVELS_BAD  = 3'h7;   // unknown mode code

   // ---------------------------------------------------------------
   // page table entry field positions
   // ---------------------------------------------------------------
   localparam int unsigned PTE_VALID   = 0;
   localparam int unsigned PTE_READ    = 1;
   localparam int unsigned PTE_WRITE   = 2;
   localparam int unsigned PTE_EXEC    = 3;
   localparam int unsigned PTE_USER    = 4;
   localparam int unsigned PTE_GLOBAL  = 5;
   localparam int unsigned PTE_ACCESS  = 6;
   localparam int unsigned PTE_DIRTY   = 7;
   localparam int unsigned PTE_PPN_LSB = 10;
   localparam int unsigned PTE_PPN_MSB = 53;
   localparam int unsigned PTE_RSV_LSB = 54;   // reserved 60..54
   localparam int unsigned PTE_RSV_MSB = 60;
   localparam int unsigned PTE_MT_LSB  = 61;   // memory-type field 62..61
   localparam int unsigned PTE_MT_MSB  = 62;
   localparam int unsigned PTE_CONTIG  = 63;   // contiguous-range flag

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ACC_FETCH = 2'b00,
      ACC_LOAD  = 2'b01,
      ACC_STORE = 2'b10
   } ptw_acc_type;

   typedef struct packed {
      logic [VA_WIDTH-1:0] vaddr;
      ptw_acc_type         acc;
   } ptw_req_type;

   typedef struct packed {
      logic [PA_WIDTH-1:0] paddr;
      logic                fault;   // page fault of kind acc
      ptw_acc_type         acc;
   } ptw_rsp_type;

endpackage

// [hdl/ptw_walker.sv]
// Purpose: virtual to physical translation by hardware page table walk
// Assumes: memory answers each entry read in order, one answer per read
// Notes:   translation mode and root are sampled when a request is taken
`timescale 1ns/1ns

module ptw_walker #(
   parameter int unsigned MAX_LEVELS = 5   // 3, 4 or 5 supported table depth
) (
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst,
   input  wire logic [3:0]                  i_satp_mode,
   input  wire logic [ptw_pkg::PPN_WIDTH-1:0] i_satp_ppn,
   input  wire logic                        i_req_valid,
   input  wire ptw_pkg::ptw_req_type        i_req,
   output logic                             o_req_ready,
   output logic                             o_rsp_valid,
   output ptw_pkg::ptw_rsp_type             o_rsp,
   output logic                             o_mem_valid,
   output logic [ptw_pkg::PA_WIDTH-1:0]     o_mem_addr,
   input  wire logic                        i_mem_ready,
   input  wire logic                        i_mem_rsp_valid,
   input  wire logic [63:0]                 i_mem_rsp_data
);
   import ptw_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // mode code to level count; deeper modes need the shallower ones
   function automatic logic [2:0] mode_levels(input logic [3:0] mode);
      logic [2:0] lv;
      lv = LEVELS_BAD;
      unique case (mode)
         MODE_BARE: lv = LEVELS_NONE;
         MODE_VA39: lv = LEVELS_VA39;
         MODE_VA48: lv = LEVELS_VA48;
         MODE_VA57: lv = LEVELS_VA57;
         default:   lv = LEVELS_BAD;
      endcase
      // a depth above what was built is refused; 5 implies 4 implies 3
      if (lv != LEVELS_NONE && lv != LEVELS_BAD && lv > 3'(MAX_LEVELS)) begin
         lv = LEVELS_BAD;
      end
      return lv;
   endfunction

   // 9 times a level, the bit distance of one table index
   function automatic logic [5:0] lvl_shift(input logic [2:0] lv);
      return ({3'h0, lv} << 3) + {3'h0, lv};
   endfunction

   // upper address bits must all copy the top implemented bit
   function automatic logic canonical(input logic [63:0] va, input logic [2:0] lv);
      logic [6:0] msb;
      msb = 7'(OFFSET_WIDTH) + 7'(lvl_shift(lv)) - 7'h1;      // 38, 47 or 56
      return ((va >> msb) == 64'h0) || ((~va >> msb) == 64'h0);
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WAIT = 2'b10,
      ST_RESP = 2'b11
   } ptw_state_type;

   ptw_state_type             state;
   ptw_state_type             next_state;
   ptw_req_type               req;
   ptw_req_type               next_req;
   logic [2:0]                level;
   logic [2:0]                next_level;
   logic [PPN_WIDTH-1:0]      table_ppn;
   logic [PPN_WIDTH-1:0]      next_table_ppn;
   ptw_rsp_type               rsp;
   ptw_rsp_type               next_rsp;

   // ---------------------------------------------------------------
   // entry decode for the word returned by memory
   // ---------------------------------------------------------------
   logic [63:0]               pte;
   logic [PPN_WIDTH-1:0]      pte_ppn;
   logic [5:0]                cur_shift;
   logic [PPN_WIDTH-1:0]      low_mask;
   logic [PPN_WIDTH-1:0]      va_vpn;
   logic [VPN_FIELD_BITS-1:0] vpn_index;
   logic                      pte_rsv_bad;
   logic                      pte_bad;
   logic                      pte_leaf;
   logic                      pte_misaligned;
   logic [PPN_WIDTH-1:0]      leaf_ppn;

   assign pte       = i_mem_rsp_data;
   assign pte_ppn   = pte[PTE_PPN_MSB:PTE_PPN_LSB];
   assign cur_shift = lvl_shift(level);
   assign va_vpn    = req.vaddr[PA_WIDTH-1:OFFSET_WIDTH];
   // index into the current table: vpn field of this level
   assign vpn_index = VPN_FIELD_BITS'(req.vaddr >> (7'(OFFSET_WIDTH) + 7'(cur_shift)));
   // ppn bits below this level, those a superpage takes from the vpn
   assign low_mask  = ~(44'hfffffffffff << cur_shift);

   // reserved high bits: no contiguous-range or memory-type support here
   assign pte_rsv_bad = pte[PTE_CONTIG]
                      | (|pte[PTE_MT_MSB:PTE_MT_LSB])
                      | (|pte[PTE_RSV_MSB:PTE_RSV_LSB]);
   // flag bits keep their usual meaning; the rest are not checked here
   assign pte_bad  = ~pte[PTE_VALID]
                   | (~pte[PTE_READ] & pte[PTE_WRITE])
                   | pte_rsv_bad;
   assign pte_leaf = pte[PTE_READ] | pte[PTE_EXEC];
   // a leaf above level 0 must have zero ppn bits below it
   assign pte_misaligned = (level != 3'h0) && ((pte_ppn & low_mask) != 44'h0);
   // superpage: low fields from the vpn, upper fields from the entry
   assign leaf_ppn = (pte_ppn & ~low_mask) | (va_vpn & low_mask);

   // ---------------------------------------------------------------
   // walk sequencing: next values
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0] lv;
      lv             = mode_levels(i_satp_mode);
      next_state     = state;
      next_req       = req;
      next_level     = level;
      next_table_ppn = table_ppn;
      next_rsp       = rsp;
      unique case (state)
         ST_IDLE: begin
            if (i_req_valid) begin
               next_req       = i_req;
               next_rsp.acc   = i_req.acc;
               next_rsp.fault = 1'b0;
               next_rsp.paddr = i_req.vaddr[PA_WIDTH-1:0];
               next_table_ppn = i_satp_ppn;
               if (lv == LEVELS_NONE) begin
                  // bare mode: address passes through untranslated
                  next_state = ST_RESP;
               end else if (lv == LEVELS_BAD) begin
                  next_rsp.fault = 1'b1;
                  next_state     = ST_RESP;
               end else if (!canonical(i_req.vaddr, lv)) begin
                  next_rsp.fault = 1'b1;
                  next_state     = ST_RESP;
               end else begin
                  next_level = lv - 3'h1;
                  next_state = ST_READ;
               end
            end
         end
         ST_READ: begin
            if (i_mem_ready) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (i_mem_rsp_valid) begin
               next_state = ST_RESP;
               if (pte_bad) begin
                  next_rsp.fault = 1'b1;
               end else if (pte_leaf) begin
                  if (pte_misaligned) begin
                     next_rsp.fault = 1'b1;
                  end else begin
                     next_rsp.paddr = {leaf_ppn, req.vaddr[OFFSET_WIDTH-1:0]};
                  end
               end else if (level == 3'h0) begin
                  next_rsp.fault = 1'b1;
               end else begin
                  // pointer: descend into the next table
                  next_table_ppn = pte_ppn;
                  next_level     = level - 3'h1;
                  next_state     = ST_READ;
               end
            end
         end
         ST_RESP: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // walk sequencing: registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state     <= ST_IDLE;
         req       <= '0;
         level     <= 3'h0;
         table_ppn <= 44'h0;
         rsp       <= '0;
      end else begin
         state     <= next_state;
         req       <= next_req;
         level     <= next_level;
         table_ppn <= next_table_ppn;
         rsp       <= next_rsp;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------

   // one request at a time; taken only while idle
   assign o_req_ready = (state == ST_IDLE);
   // answer stands for exactly one cycle
   assign o_rsp_valid = (state == ST_RESP);
   assign o_rsp       = rsp;
   // entry address: table base page plus index times entry size
   assign o_mem_valid = (state == ST_READ);
   assign o_mem_addr  = {table_ppn, 12'h000}
                      + {44'h0, vpn_index, 3'h0};

endmodule

// [dv/ptw_mem_model.sv]
// Purpose: memory holding the page tables, answers entry reads
// Assumes: one read outstanding, answer after i_delay extra cycles
// Notes:   an address never written reads as zero, an invalid entry
`timescale 1ns/1ns
module ptw_mem_model (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_delay,
   input  wire logic        i_mem_valid,
   input  wire logic [55:0] i_mem_addr,
   output logic             o_mem_ready,
   output logic             o_mem_rsp_valid,
   output logic [63:0]      o_mem_rsp_data
);
   logic [63:0] mem [logic [55:0]];  // tables page aligned, 8-byte entries
   logic        pend;
   logic [55:0] addr;
   logic [3:0]  cnt;
   // no new read while one is pending
   assign o_mem_ready = !pend;
   // accept, wait, then answer with the whole entry
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pend            <= 1'b0;
         o_mem_rsp_valid <= 1'b0;
         o_mem_rsp_data  <= 64'h0;
      end else begin
         o_mem_rsp_valid <= 1'b0;
         o_mem_rsp_data  <= ~o_mem_rsp_data;  // bus inverted each cycle; the old entry returns every second cycle
         if (pend && cnt == 4'h0) begin
            pend            <= 1'b0;
            o_mem_rsp_valid <= 1'b1;
            o_mem_rsp_data  <= mem.exists(addr) ? mem[addr] : 64'h0;
         end else if (pend) begin
            cnt <= cnt - 4'h1;
         end else if (i_mem_valid) begin
            pend <= 1'b1;
            addr <= i_mem_addr;
            cnt  <= i_delay;
         end
      end
   end
endmodule

// [dv/ptw_walker_checker.sv]
// Purpose: port-level checks of the page table walker
// Assumes: one request and one entry read outstanding
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ns
module ptw_walker_checker
   import ptw_pkg::*;
#(
   parameter int unsigned MAX_LEVELS = 5
) (
   input wire logic                          i_mclk,
   input wire logic                          i_rst,
   input wire logic [3:0]                    i_satp_mode,
   input wire logic [ptw_pkg::PPN_WIDTH-1:0] i_satp_ppn,
   input wire logic                          i_req_valid,
   input wire ptw_pkg::ptw_req_type          i_req,
   input wire logic                          o_req_ready,
   input wire logic                          o_rsp_valid,
   input wire ptw_pkg::ptw_rsp_type          o_rsp,
   input wire logic                          o_mem_valid,
   input wire logic [ptw_pkg::PA_WIDTH-1:0]  o_mem_addr,
   input wire logic                          i_mem_ready,
   input wire logic                          i_mem_rsp_valid,
   input wire logic [63:0]                   i_mem_rsp_data
);
   logic        take;
   logic        wt;
   logic [63:0] va;
   logic [43:0] rt;
   logic [63:0] d;
   // request taken: valid while the walker is ready
   assign take = i_req_valid && o_req_ready;
   assign d    = i_mem_rsp_data;
   // capture request and entry read state
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         wt <= 1'b0;
         va <= 64'h0;
         rt <= 44'h0;
      end else begin
         if (take) begin
            va <= i_req.vaddr;
            rt <= i_satp_ppn;
         end
         if (o_mem_valid && i_mem_ready) wt <= 1'b1;
         else if (i_mem_rsp_valid) wt <= 1'b0;
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   rsp_pulse_a: assert property (o_rsp_valid |=> !o_rsp_valid && o_req_ready)
      else $error("answer pulse too long or no ready after it");
   root_39_a: assert property (take && i_satp_mode == MODE_VA39 && ($countones(i_req.vaddr[63:38]) % 26 == 0) |=> o_mem_valid && o_mem_addr == {rt, va[38:30], 3'h0})
      else $error("wrong first entry address in 39-bit mode");
   root_57_a: assert property (MAX_LEVELS >= 5 && take && i_satp_mode == MODE_VA57 && ($countones(i_req.vaddr[63:56]) % 8 == 0) |=> o_mem_valid && o_mem_addr == {rt, va[56:48], 3'h0})
      else $error("wrong first entry address in 57-bit mode");
   canon_39_a: assert property (take && i_satp_mode == MODE_VA39 && ($countones(i_req.vaddr[63:38]) % 26 != 0) |=> o_rsp_valid && o_rsp.fault && !o_mem_valid)
      else $error("non-canonical 39-bit address not faulted");
   canon_48_a: assert property (take && i_satp_mode == MODE_VA48 && ($countones(i_req.vaddr[63:47]) % 17 != 0) |=> o_rsp_valid && o_rsp.fault && !o_mem_valid)
      else $error("non-canonical 48-bit address not faulted");
   offset_kept_a: assert property (o_rsp_valid && !o_rsp.fault |-> o_rsp.paddr[11:0] == va[11:0])
      else $error("page offset changed");
   rsv_fault_a: assert property (wt && i_mem_rsp_valid && |d[63:54] |=> o_rsp_valid && o_rsp.fault)
      else $error("reserved entry bits not faulted");
   invalid_fault_a: assert property (wt && i_mem_rsp_valid && (!d[0] || (!d[1] && d[2])) |=> o_rsp_valid && o_rsp.fault)
      else $error("invalid entry not faulted");
   next_level_a: assert property (wt && i_mem_rsp_valid && d[3:0] == 4'h1 && d[63:54] == 10'h0 |=> (o_mem_valid && o_mem_addr[55:12] == $past(d[53:10])) || (o_rsp_valid && o_rsp.fault))
      else $error("pointer entry not followed");
   cover property (o_rsp_valid && !o_rsp.fault);
   cover property (o_rsp_valid && o_rsp.fault);
   cover property (take && i_satp_mode == MODE_VA57);
endmodule
bind ptw_walker ptw_walker_checker #(.MAX_LEVELS(MAX_LEVELS)) chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_satp_mode(i_satp_mode), .i_satp_ppn(i_satp_ppn), .i_req_valid(i_req_valid), .i_req(i_req),
   .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_mem_valid(o_mem_valid),
   .o_mem_addr(o_mem_addr), .i_mem_ready(i_mem_ready), .i_mem_rsp_valid(i_mem_rsp_valid),
   .i_mem_rsp_data(i_mem_rsp_data));

// [dv/ptw_walker_test.sv]
// Purpose: self-checking bench for the page table walker
// Assumes: root table at page 100, tables built before the run
// Notes:   mode and root are scrambled after each take in run on purpose
`timescale 1ns/1ns
module ptw_walker_test;
   import ptw_pkg::*;
   typedef struct {logic [3:0] m; logic [63:0] va; logic f; logic [55:0] pa;} ptw_row_type;
   logic        i_mclk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0;
   logic [3:0]  i_satp_mode = 4'h0, mem_delay = 4'h0;
   logic [43:0] i_satp_ppn = 44'h0;
   ptw_req_type i_req = '0;
   ptw_rsp_type o_rsp;
   logic        o_req_ready, o_rsp_valid, o_mem_valid, mem_ready, mem_rsp_valid;
   logic [55:0] o_mem_addr;
   logic [63:0] mem_rsp_data;
   ptw_row_type rows[$];
   int          n_errors = 0, n_tests = 0;
   ptw_walker DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_satp_mode(i_satp_mode),
      .i_satp_ppn(i_satp_ppn), .i_req_valid(i_req_valid), .i_req(i_req),
      .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
      .o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr), .i_mem_ready(mem_ready),
      .i_mem_rsp_valid(mem_rsp_valid), .i_mem_rsp_data(mem_rsp_data));
   ptw_mem_model u_mem (.i_mclk(i_mclk), .i_rst(i_rst), .i_delay(mem_delay),
      .i_mem_valid(o_mem_valid), .i_mem_addr(o_mem_addr), .o_mem_ready(mem_ready),
      .o_mem_rsp_valid(mem_rsp_valid), .o_mem_rsp_data(mem_rsp_data));
   always #5 i_mclk = ~i_mclk;
   task automatic close_out;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic add(input logic [3:0] m, input logic [63:0] va, input logic f,
                      input logic [55:0] pa);
      rows.push_back('{m, va, f, pa});
   endtask
   // one translation: present at a falling edge, hold until taken, wait for the answer
   task automatic run(input int i);
      int w;
      @(negedge i_mclk);
      i_satp_mode = rows[i].m;
      i_satp_ppn  = 44'h100;
      i_req       = '{vaddr: rows[i].va, acc: ptw_acc_type'(i % 3)};
      i_req_valid = 1'b1;
      mem_delay   = 4'(i % 4);
      while (!o_req_ready) @(negedge i_mclk);
      @(negedge i_mclk);
      i_req_valid = 1'b0;
      i_satp_mode = 4'h1;  // later mode and root must not matter
      i_satp_ppn  = 44'h0;
      for (w = 0; w < 300 && o_rsp_valid !== 1'b1; w++) begin
         @(posedge i_mclk);
         #1;
      end
      if (w == 300) n_errors++;
      chk(64'(o_rsp.fault), 64'(rows[i].f));
      chk(64'(o_rsp.acc), 64'(i % 3));
      if (!rows[i].f) chk(64'(o_rsp.paddr), 64'(rows[i].pa));
   endtask
   initial begin
      #100000;
      n_errors++;
      close_out;
   end
   initial begin
      // page tables: root 100, then 101 and 102; root slot 0 points back to the root
      u_mem.mem[56'h100000] = 64'h40001;
      u_mem.mem[56'h100008] = 64'h40401;
      u_mem.mem[56'h100010] = 64'h3000_0009;
      u_mem.mem[56'h100808] = 64'h40401;
      u_mem.mem[56'h101010] = 64'h40801;
      u_mem.mem[56'h101020] = 64'h100003;
      u_mem.mem[56'h101028] = 64'h100403;
      u_mem.mem[56'h101030] = 64'h8000_0000_0018_0003;
      u_mem.mem[56'h101038] = 64'h2000_0000_0018_0003;
      u_mem.mem[56'h101040] = 64'h0040_0000_0018_0003;
      u_mem.mem[56'h101050] = 64'h5;
      u_mem.mem[56'h102018] = 64'hd1407;
      u_mem.mem[56'h102020] = 64'h401;
      add(MODE_VA39, 64'h4040_3abc, 1'b0, 56'h345abc);
      add(MODE_VA39, 64'h4080_3abc, 1'b0, 56'h403abc);
      add(MODE_VA39, 64'h8040_3abc, 1'b0, 56'hc040_3abc);
      add(MODE_VA39, 64'hffff_ffc0_4040_3abc, 1'b0, 56'h345abc);
      add(MODE_VA39, 64'h80_4040_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h40a0_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h40c0_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h40e0_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h4100_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h4120_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h4140_3abc, 1'b1, 56'h0);
      add(MODE_VA39, 64'h4040_4abc, 1'b1, 56'h0);
      add(MODE_VA48, 64'h4040_3abc, 1'b0, 56'h345abc);
      add(MODE_VA48, 64'h1_0000_4040_3abc, 1'b1, 56'h0);
      add(MODE_VA57, 64'h4040_3abc, 1'b0, 56'h345abc);
      add(MODE_VA57, 64'h200_0000_4040_3abc, 1'b1, 56'h0);
      add(MODE_BARE, 64'h1234_5678_9abc_def0, 1'b0, 56'h34_5678_9abc_def0);
      add(4'h1, 64'h4040_3abc, 1'b1, 56'h0);
      repeat (10) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst = 1'b0;
      foreach (rows[i]) run(i);
      // reset in mid-walk returns the walker to idle, then it works again
      @(negedge i_mclk);
      i_satp_mode = MODE_VA39;
      i_satp_ppn  = 44'h100;
      i_req_valid = 1'b1;
      mem_delay   = 4'hf;
      @(negedge i_mclk);
      i_req_valid = 1'b0;
      repeat (3) @(negedge i_mclk);
      i_rst = 1'b1;
      #1;
      chk(64'({o_req_ready, o_rsp_valid, o_mem_valid}), 64'h4);
      chk(64'(o_rsp), 64'h0);  // answer register cleared by reset
      @(negedge i_mclk);
      i_rst = 1'b0;
      run(0);
      close_out;
   end
endmodule
